// [rtl/oscrt_pkg.sv]
// constants for the oscillator select and fast rc trim block
package oscrt_pkg;
  // register byte addresses
  localparam logic [7:0] OSCRT_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] OSCRT_ADDR_TRIM    = 8'h04;
  localparam logic [7:0] OSCRT_ADDR_UNLOCK  = 8'h08;
  localparam logic [7:0] OSCRT_ADDR_STATUS  = 8'h0c;
  // control and trim register fields
  localparam int OSCRT_BIT_SWITCH_REQ = 0;
  localparam int OSCRT_BIT_SEC_OSC_EN = 1;
  localparam int OSCRT_BIT_USB_FROM_RC = 2;
  localparam int OSCRT_NOSC_LSB = 8;
  localparam int OSCRT_NOSC_W = 3;
  localparam int OSCRT_COSC_LSB = 12;
  localparam int OSCRT_TRIM_W = 6;
  // unlock keys written in order to the unlock register
  localparam logic [31:0] OSCRT_KEY1 = 32'haa99_6655;
  localparam logic [31:0] OSCRT_KEY2 = 32'h5566_99aa;
  // reset values
  localparam logic [2:0] OSCRT_SRC_RESET  = 3'h0;
  localparam logic [5:0] OSCRT_TRIM_RESET = 6'h00;
  // switch settle time
  localparam int OSCRT_SWITCH_NS = 200;
  localparam int OSCRT_CLK_NS = 10;
  localparam int OSCRT_SWITCH_CYC = (OSCRT_SWITCH_NS + OSCRT_CLK_NS - 1) / OSCRT_CLK_NS;
  typedef enum logic [1:0] {OSCRT_LOCKED, OSCRT_KEY1_SEEN, OSCRT_OPEN} oscrt_lock_e;
endpackage : oscrt_pkg

// [rtl/oscrt_top.sv]
// oscillator select, clock switch and fast rc trim registers
`timescale 1ns/1ps
module oscrt_top
  import oscrt_pkg::*;
#(
  parameter int SWITCH_CYC = OSCRT_SWITCH_CYC
)(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             USB_CLK_FROM_RC,
  output logic             SEC_OSC_ENABLE,
  output logic      [2:0]  CUR_CLOCK_SOURCE,
  output logic             SWITCH_BUSY,
  output logic signed [5:0] RC_TRIM_VALUE
);
  // ********************************************
  // storage
  // ********************************************
  // counter width, wide enough for any sensible settle count
  localparam int CNT_W = 16;

  oscrt_lock_e      lock_reg;
  oscrt_lock_e      lock_next;
  logic             usb_rc_reg;
  logic             usb_rc_next;
  logic             sosc_reg;
  logic             sosc_next;
  logic             req_reg;
  logic             req_next;
  logic [2:0]       nosc_reg;
  logic [2:0]       nosc_next;
  logic [2:0]       cosc_reg;
  logic [2:0]       cosc_next;
  logic [5:0]       trim_reg;
  logic [5:0]       trim_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;

  // ********************************************
  // functions
  // ********************************************
  // true when the bus address selects the given register
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_hit = a == reg_addr;
  endfunction : addr_hit

  // true when an unlock write carries the given key
  function automatic logic key_hit(input logic [31:0] d, input logic [31:0] key);
    key_hit = d == key;
  endfunction : key_hit

  // ********************************************
  // bus decode
  // ********************************************
  // write strobes per register
  wire wr_ctl    = WR && addr_hit(ADDR, OSCRT_ADDR_CONTROL);
  wire wr_trim   = WR && addr_hit(ADDR, OSCRT_ADDR_TRIM);
  wire wr_unlock = WR && addr_hit(ADDR, OSCRT_ADDR_UNLOCK);
  wire any_acc   = WR || RD;                          // any access closes the key window
  wire key1_ok   = wr_unlock && key_hit(WDATA, OSCRT_KEY1);
  wire key2_ok   = wr_unlock && key_hit(WDATA, OSCRT_KEY2);

  // protected writes land only while the gate is open
  wire unlocked  = lock_reg == OSCRT_OPEN;
  wire ctl_ok    = wr_ctl && unlocked;
  wire trim_ok   = wr_trim && unlocked;

  // a switch starts only from idle, writing zero never aborts it
  wire start     = ctl_ok && WDATA[OSCRT_BIT_SWITCH_REQ] && !req_reg;
  wire done      = req_reg && cnt_reg == CNT_W'(SWITCH_CYC - 1);

  // ********************************************
  // unlock sequence
  // ********************************************
  // key one, then key two as the very next access, then exactly one
  // protected write, after which the gate shuts again
  always_comb
  begin
    lock_next = lock_reg;
    case (lock_reg)
      OSCRT_LOCKED:
      begin
        if (key1_ok)
          lock_next = OSCRT_KEY1_SEEN;
      end
      OSCRT_KEY1_SEEN:
      begin
        if (any_acc)
          lock_next = key2_ok ? OSCRT_OPEN : OSCRT_LOCKED;
      end
      OSCRT_OPEN:
      begin
        if (wr_ctl || wr_trim)
          lock_next = OSCRT_LOCKED;
      end
      default:
        lock_next = OSCRT_LOCKED;
    endcase
  end

  // gate state register
  always_ff @(posedge CLK)
  begin
    if (RESET)
      lock_reg <= OSCRT_LOCKED;
    else
      lock_reg <= lock_next;
  end

  // ********************************************
  // control register fields
  // ********************************************
  // usb clock source select, written only when open
  assign usb_rc_next = ctl_ok ? WDATA[OSCRT_BIT_USB_FROM_RC] : usb_rc_reg;
  // secondary oscillator runs while its bit is set
  assign sosc_next   = ctl_ok ? WDATA[OSCRT_BIT_SEC_OSC_EN] : sosc_reg;
  // target source is frozen while a switch runs
  assign nosc_next   = (ctl_ok && !req_reg) ? WDATA[OSCRT_NOSC_LSB +: OSCRT_NOSC_W]
                                            : nosc_reg;

  // control field registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      usb_rc_reg <= 1'b0;
      sosc_reg   <= 1'b0;
      nosc_reg   <= OSCRT_SRC_RESET;
    end
    else
    begin
      usb_rc_reg <= usb_rc_next;
      sosc_reg   <= sosc_next;
      nosc_reg   <= nosc_next;
    end
  end

  // ********************************************
  // switch sequencer
  // ********************************************
  // request bit stays set and the old source keeps running until the
  // settle count has elapsed, then the new source takes over at once
  always_comb
  begin
    req_next  = req_reg;
    cosc_next = cosc_reg;
    cnt_next  = cnt_reg;
    if (start)
    begin
      req_next = 1'b1;
      cnt_next = '0;
    end
    else if (done)
    begin
      req_next  = 1'b0;
      cosc_next = nosc_reg;
    end
    else if (req_reg)
      cnt_next = cnt_reg + CNT_W'(1);
  end

  // sequencer registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      req_reg  <= 1'b0;
      cosc_reg <= OSCRT_SRC_RESET;
      cnt_reg  <= '0;
    end
    else
    begin
      req_reg  <= req_next;
      cosc_reg <= cosc_next;
      cnt_reg  <= cnt_next;
    end
  end

  // ********************************************
  // trim register, zero is the 8 MHz centre
  // ********************************************
  // six bit field, only written when open
  assign trim_next = trim_ok ? WDATA[OSCRT_TRIM_W-1:0] : trim_reg;

  // trim register, power-on value is the centre
  always_ff @(posedge CLK)
  begin
    if (RESET)
      trim_reg <= OSCRT_TRIM_RESET;
    else
      trim_reg <= trim_next;
  end

  // ********************************************
  // read port
  // ********************************************
  // read views of the control, trim and status registers, unused bits read zero
  wire [31:0] ctl_rd  = {16'h0000, 1'b0, cosc_reg, 1'b0, nosc_reg, 5'h00,
                         usb_rc_reg, sosc_reg, req_reg};
  wire [31:0] trim_rd = {26'h0000000, trim_reg};
  wire [31:0] stat_rd = {30'h00000000, req_reg, unlocked};

  // address select, unmapped reads give zero
  wire [31:0] rd_mux  = addr_hit(ADDR, OSCRT_ADDR_CONTROL) ? ctl_rd :
                        addr_hit(ADDR, OSCRT_ADDR_TRIM)    ? trim_rd :
                        addr_hit(ADDR, OSCRT_ADDR_STATUS)  ? stat_rd : 32'h00000000;
  // data stand for one cycle after the read strobe only
  assign rdata_next   = RD ? rd_mux : 32'h00000000;

  // read data register
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  // ********************************************
  // outputs
  // ********************************************
  // all outputs come straight from registers, trim signed
  assign RDATA            = rdata_reg;
  assign USB_CLK_FROM_RC  = usb_rc_reg;
  assign SEC_OSC_ENABLE   = sosc_reg;
  assign CUR_CLOCK_SOURCE = cosc_reg;
  assign SWITCH_BUSY      = req_reg;
  assign RC_TRIM_VALUE    = $signed(trim_reg);
endmodule : oscrt_top

// [verification/oscrt_properties.sv]
// checker for the oscillator select and rc trim block
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module oscrt_properties
  import oscrt_pkg::*;
(
  input wire logic CLK, RESET, WR, RD, USB_CLK_FROM_RC,
  input wire logic SEC_OSC_ENABLE, SWITCH_BUSY,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA, RDATA,
  input wire logic [2:0] CUR_CLOCK_SOURCE,
  input wire logic signed [5:0] RC_TRIM_VALUE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // a switch begins
  sequence s_go; $rose(SWITCH_BUSY); endsequence
  a_usb_rc_sel: assert property ($changed(USB_CLK_FROM_RC) |-> $past(WR) && $past(ADDR) == OSCRT_ADDR_CONTROL)
    else $error("usb select moved alone");
  a_sec_osc_en: assert property ($changed(SEC_OSC_ENABLE) |-> $past(WR) && $past(ADDR) == OSCRT_ADDR_CONTROL)
    else $error("sec osc moved alone");
  a_trim_guard: assert property ($changed(RC_TRIM_VALUE) |-> $past(WR) && $past(ADDR) == OSCRT_ADDR_TRIM)
    else $error("trim moved alone");
  a_switch_start: assert property (s_go |-> $past(WR) && $past(WDATA[0]))
    else $error("switch began alone");
  a_switch_done: assert property (s_go |-> ##[1:40] !SWITCH_BUSY)
    else $error("switch never ends");
  a_busy_hold: assert property (s_go |-> SWITCH_BUSY[*8])
    else $error("busy dropped early");
  a_src_kept: assert property (SWITCH_BUSY |-> $stable(CUR_CLOCK_SOURCE))
    else $error("source moved early");
  a_trim_upper: assert property (RD && ADDR == OSCRT_ADDR_TRIM |=> RDATA[31:6] == 26'h0)
    else $error("trim upper bits set");
endmodule : oscrt_properties
bind oscrt_top oscrt_properties i_oscrt_properties (.*);

// [verification/oscrt_top_tb.sv]
// self-checking bench for the oscillator select and rc trim block
`timescale 1ns/1ps
// ****************
// bench
// ****************
module oscrt_top_tb;
  import oscrt_pkg::*;
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, USB_CLK_FROM_RC, SEC_OSC_ENABLE, SWITCH_BUSY;
  logic [7:0] ADDR = 0;
  logic [31:0] WDATA = 0, RDATA;
  logic [2:0] CUR_CLOCK_SOURCE;
  logic signed [5:0] RC_TRIM_VALUE;
  int fails = 0, checks_done = 0;
  oscrt_top #(.SWITCH_CYC(12)) i_oscrt_top (.*);
  initial forever #5 CLK = ~CLK;
  // compare and count
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    fails += (g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask : chk
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(logic [7:0] a, string n, logic [31:0] e);
    @(posedge CLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(n, e, RDATA);
  endtask : rd
  // unlock, then one guarded write
  task uw(logic [7:0] a, logic [31:0] d);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY1);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY2);
    wr(a, d);
  endtask : uw
  task t_basic;
    rd(OSCRT_ADDR_TRIM, "trim rst", 0);
    chk("trim out", 0, {26'h0, RC_TRIM_VALUE});
    wr(OSCRT_ADDR_TRIM, 32'h5);
    rd(OSCRT_ADDR_TRIM, "locked", 0);
    rd(8'h10, "unmapped", 0);
    $display("t_basic done");
  endtask : t_basic
  task t_trim;
    uw(OSCRT_ADDR_TRIM, 32'hffff_ffe0);
    rd(OSCRT_ADDR_TRIM, "trim low", 32'h20);
    chk("trim out", 32'h20, {26'h0, RC_TRIM_VALUE});
    wr(OSCRT_ADDR_TRIM, 32'h1);
    rd(OSCRT_ADDR_TRIM, "relock", 32'h20);
    $display("t_trim done");
  endtask : t_trim
  task t_ctrl;
    uw(OSCRT_ADDR_CONTROL, 32'h6);
    #1 chk("usb rc", 1, USB_CLK_FROM_RC);
    chk("sec osc", 1, SEC_OSC_ENABLE);
    uw(OSCRT_ADDR_CONTROL, 32'h307);
    #1 chk("busy", 1, SWITCH_BUSY);
    chk("old src", 0, CUR_CLOCK_SOURCE);
    uw(OSCRT_ADDR_CONTROL, 32'h506);
    #1 chk("frozen busy", 1, SWITCH_BUSY);
    chk("frozen src", 0, CUR_CLOCK_SOURCE);
    repeat (100) if (SWITCH_BUSY) #10;
    chk("done", 0, SWITCH_BUSY);
    if (SWITCH_BUSY) report_and_stop();
    chk("new src", 3, CUR_CLOCK_SOURCE);
    rd(OSCRT_ADDR_CONTROL, "ctrl", 32'h3306);
    $display("t_ctrl done");
  endtask : t_ctrl
  task t_lock;
    uw(OSCRT_ADDR_CONTROL, 32'h0);
    #1 chk("usb off", 0, USB_CLK_FROM_RC);
    chk("sec off", 0, SEC_OSC_ENABLE);
    rd(OSCRT_ADDR_STATUS, "relocked", 0);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY1);
    rd(OSCRT_ADDR_STATUS, "broken seq", 0);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY2);
    wr(OSCRT_ADDR_CONTROL, 32'h6);
    #1 chk("still locked", 0, USB_CLK_FROM_RC);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY1);
    wr(OSCRT_ADDR_UNLOCK, OSCRT_KEY2);
    rd(OSCRT_ADDR_STATUS, "open", 1);
    $display("t_lock done");
  endtask : t_lock
  task report_and_stop;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    t_basic();
    t_trim();
    t_ctrl();
    t_lock();
    report_and_stop();
  end
endmodule : oscrt_top_tb
